// ==== pcm_pkg.sv ====
// Purpose: Shared constants, types and register map of the PLL clock module
// Assumes: 16-bit registers, each at one 32-bit Avalon word (byte address = 4 * index)
// Notes: Lock time is counted in oscillator cycles, not in sys_clk cycles
package pcm_pkg;

    // ==========================================================
    // Widths
    localparam int PCM_REG_W = 16;
    localparam int PCM_ADDR_W = 17;
    localparam int PCM_IDX_W = 15;
    localparam int PCM_RATIO_W = 4;
    localparam int PCM_PERIOD_W = 16;
    localparam int PCM_LOCK_W = 18;
    localparam int PCM_MEM_AW = 3;
    localparam int PCM_MEM_DEPTH = 8;

    // ==========================================================
    // Register indexes
    localparam logic [14:0] PCM_IDX_CLK_OUT_PIN = 15'h7010;
    localparam logic [14:0] PCM_IDX_PLL_STATUS = 15'h7011;
    localparam logic [14:0] PCM_IDX_PCLK_GATE2 = 15'h7019;
    localparam logic [14:0] PCM_IDX_FAST_PRESC = 15'h701A;
    localparam logic [14:0] PCM_IDX_SLOW_PRESC = 15'h701B;
    localparam logic [14:0] PCM_IDX_PCLK_GATE0 = 15'h701C;
    localparam logic [14:0] PCM_IDX_PCLK_GATE1 = 15'h701D;
    localparam logic [14:0] PCM_IDX_LOW_POWER = 15'h701E;
    localparam logic [14:0] PCM_IDX_PLL_RATIO = 15'h7021;
    localparam logic [14:0] PCM_IDX_SYS_CTRL = 15'h7022;
    localparam logic [14:0] PCM_IDX_WD_COUNT = 15'h7023;
    localparam logic [14:0] PCM_IDX_WD_KEY = 15'h7025;
    localparam logic [14:0] PCM_IDX_WD_CTRL = 15'h7029;

    // ==========================================================
    // Field positions
    localparam int PCM_SRC_LSB = 2;
    localparam int PCM_OSC_OK_BIT = 6;
    localparam int PCM_LOCKED_BIT = 0;
    localparam int PCM_HALVE_BIT = 1;
    localparam int PCM_PLL_OFF_BIT = 3;
    localparam int PCM_LPM_HALT_BIT = 1;

    // ==========================================================
    // Reset values and encodings
    localparam logic [3:0] PCM_RATIO_RST = 4'h0;
    localparam logic [3:0] PCM_RATIO_MAX = 4'hA;
    localparam logic [1:0] PCM_SRC_RST = 2'h0;
    localparam logic [1:0] PCM_SRC_EXT_PIN = 2'h2;
    localparam logic [1:0] PCM_LPM_RST = 2'h0;
    localparam logic [1:0] PCM_LPM_IDLE = 2'h0;
    localparam logic [15:0] PCM_MEM_RST = 16'h0000;

    // ==========================================================
    // Timing
    localparam int PCM_LOCK_OSC_CYCLES = 131072;
    localparam logic [1:0] PCM_BUS_LAST = 2'h2;
    localparam logic [1:0] PCM_BUS_READ = 2'h1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PCM_BYPASS,
        PCM_LOCKING,
        PCM_PLL
    } pcm_mode_t;

    typedef struct packed {
        logic bypass;
        logic pll_locked;
        logic lpm_stopped;
        logic halted;
    } pcm_clk_status_t;

endpackage : pcm_pkg

// ==== pcm_regmem.sv ====
// Purpose: Small storage for the plain read/write registers of the map
// Assumes: One write port, one read port, read data registered
// Notes: Every word clears to zero on reset
`timescale 1ns/1ps
module pcm_regmem (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Access
    input wire logic wr_en,
    input wire logic [pcm_pkg::PCM_MEM_AW-1:0] addr,
    input wire logic [pcm_pkg::PCM_REG_W-1:0] wr_data,
    output logic [pcm_pkg::PCM_REG_W-1:0] rd_data
);
    import pcm_pkg::*;

    logic [PCM_REG_W-1:0] mem [PCM_MEM_DEPTH];

    // ==========================================================
    // Storage words
    for (genvar i = 0; i < PCM_MEM_DEPTH; i++) begin : g_word
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                mem[i] <= PCM_MEM_RST;
            end else if (clk_en && wr_en && addr == PCM_MEM_AW'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // ==========================================================
    // Registered read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= PCM_MEM_RST;
        end else if (clk_en) begin
            rd_data <= mem[addr];
        end
    end

endmodule : pcm_regmem

// ==== pcm_clock_module.sv ====
// Purpose: PLL clock module: source select, ratio, bypass, lock wait, low-power entry
// Assumes: Oscillator well below sys_clk / 4; pins synchronised before use
// Notes: Multiplied clock rebuilt by a phase accumulator against the measured period
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module pcm_clock_module #(
    parameter int LOCK_OSC_CYCLES = pcm_pkg::PCM_LOCK_OSC_CYCLES
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [pcm_pkg::PCM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU side
    input wire logic protected_write_enable,
    input wire logic idle_req,
    // Clock pins
    input wire logic low_voltage_clock_pin,
    input wire logic ext_clock_pin,
    output logic crystal_drive_pin,
    output logic crystal_drive_oe,
    // Wake pin
    input wire logic wake_n,
    // Clocks and status out
    output logic cpu_clock_in,
    output logic system_clock_out,
    output pcm_pkg::pcm_clk_status_t clk_status
);
    import pcm_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [2:0] async_in;
    logic [2:0] sync_a;
    logic [2:0] sync_b;

    assign async_in = {wake_n, ext_clock_pin, low_voltage_clock_pin};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                sync_a[i] <= (i == 2) ? 1'b1 : 1'b0;
                sync_b[i] <= (i == 2) ? 1'b1 : 1'b0;
            end else if (clk_en) begin
                sync_a[i] <= async_in[i];
                sync_b[i] <= sync_a[i];
            end
        end
    end

    // ==========================================================
    // Register state
    logic [1:0] clk_src;
    logic [PCM_RATIO_W-1:0] pll_ratio_reg;
    logic input_halving_select;
    logic pll_power_off_bit;
    logic [1:0] lpm_sel;
    logic lpm_stop;
    pcm_mode_t mode;
    logic [PCM_LOCK_W-1:0] lock_cnt;

    // ==========================================================
    // Oscillator selection and edge detect
    wire ext_mode = (clk_src == PCM_SRC_EXT_PIN);
    wire crystal_mode = (clk_src == PCM_SRC_RST);
    wire halted = lpm_stop & lpm_sel[PCM_LPM_HALT_BIT];
    wire osc_level = ext_mode ? sync_b[1] : sync_b[0];
    logic osc_prev;
    wire osc_rise = osc_level & ~osc_prev & ~halted;

    // Period of the oscillator in sys_clk cycles
    logic [PCM_PERIOD_W-1:0] per_cnt;
    logic [PCM_PERIOD_W-1:0] osc_period;
    wire per_full = &per_cnt;
    wire osc_ok = ~per_full;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_prev <= 1'b0;
            per_cnt <= '0;
            osc_period <= '1;
        end else if (clk_en) begin
            osc_prev <= osc_level;
            if (osc_rise) begin
                per_cnt <= '0;
                osc_period <= per_cnt + PCM_PERIOD_W'(1);
            end else if (!per_full) begin
                per_cnt <= per_cnt + PCM_PERIOD_W'(1);
            end
        end
    end

    // Crystal amplifier drives the inverse of the crystal input
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            crystal_drive_pin <= 1'b0;
            crystal_drive_oe <= 1'b0;
        end else if (clk_en) begin
            crystal_drive_pin <= ~sync_b[0];
            crystal_drive_oe <= crystal_mode & ~halted;
        end
    end

    // ==========================================================
    // Bus slave: two wait cycles, answer at the third edge
    logic [1:0] bus_cnt;
    wire bus_req = avs_read | avs_write;
    wire bus_done = bus_req & (bus_cnt == PCM_BUS_LAST);
    wire [PCM_IDX_W-1:0] idx = avs_address[PCM_ADDR_W-1:2];
    wire wr_fire = avs_write & bus_done & protected_write_enable;
    wire [15:0] wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    assign avs_waitrequest = bus_req & (bus_cnt != PCM_BUS_LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_cnt <= 2'h0;
        end else if (clk_en) begin
            bus_cnt <= (bus_req && !bus_done) ? bus_cnt + 2'h1 : 2'h0;
        end
    end

    // Address decode
    wire hit_clock_out_pin_control = (idx == PCM_IDX_CLK_OUT_PIN);
    wire hit_sts = (idx == PCM_IDX_PLL_STATUS);
    wire hit_lpm = (idx == PCM_IDX_LOW_POWER);
    wire hit_ratio = (idx == PCM_IDX_PLL_RATIO);
    wire hit_wdcnt = (idx == PCM_IDX_WD_COUNT);
    wire hit_mem = (idx == PCM_IDX_PCLK_GATE2) | (idx == PCM_IDX_FAST_PRESC)
        | (idx == PCM_IDX_SLOW_PRESC) | (idx == PCM_IDX_PCLK_GATE0)
        | (idx == PCM_IDX_PCLK_GATE1) | (idx == PCM_IDX_SYS_CTRL)
        | (idx == PCM_IDX_WD_KEY) | (idx == PCM_IDX_WD_CTRL);
    wire [PCM_MEM_AW-1:0] mem_slot =
        (idx == PCM_IDX_PCLK_GATE2) ? 3'h0 :
        (idx == PCM_IDX_FAST_PRESC) ? 3'h1 :
        (idx == PCM_IDX_SLOW_PRESC) ? 3'h2 :
        (idx == PCM_IDX_PCLK_GATE0) ? 3'h3 :
        (idx == PCM_IDX_PCLK_GATE1) ? 3'h4 :
        (idx == PCM_IDX_SYS_CTRL) ? 3'h5 :
        (idx == PCM_IDX_WD_KEY) ? 3'h6 : 3'h7;

    // ==========================================================
    // Register views and write merge
    logic [15:0] mem_rdata;
    wire pll_locked = (mode == PCM_PLL);
    wire [15:0] clock_out_pin_control_view = 16'(clk_src) << PCM_SRC_LSB
        | 16'(osc_ok) << PCM_OSC_OK_BIT;
    wire [15:0] sts_view = 16'(pll_locked) << PCM_LOCKED_BIT
        | 16'(input_halving_select) << PCM_HALVE_BIT
        | 16'(pll_power_off_bit) << PCM_PLL_OFF_BIT;
    wire [15:0] ratio_view = 16'(pll_ratio_reg);
    wire [15:0] lpm_view = 16'(lpm_sel);
    wire [15:0] old_val =
        hit_clock_out_pin_control ? clock_out_pin_control_view :
        hit_sts ? sts_view :
        hit_lpm ? lpm_view :
        hit_ratio ? ratio_view :
        hit_wdcnt ? 16'h0000 :
        hit_mem ? mem_rdata : 16'h0000;
    wire [15:0] merged = (old_val & ~wr_mask) | (avs_writedata[15:0] & wr_mask);

    pcm_regmem u_regmem (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .wr_en(wr_fire & hit_mem),
        .addr(mem_slot),
        .wr_data(merged),
        .rd_data(mem_rdata)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (clk_en && avs_read && bus_cnt == PCM_BUS_READ) begin
            avs_readdata <= {16'h0000, old_val};
        end
    end

    // ==========================================================
    // Control registers
    wire [PCM_RATIO_W-1:0] new_ratio = merged[PCM_RATIO_W-1:0];
    wire ratio_ok = (new_ratio <= PCM_RATIO_MAX);
    wire wr_ratio = wr_fire & hit_ratio & ratio_ok;
    wire wr_sts = wr_fire & hit_sts;
    wire ratio_zero = (pll_ratio_reg == PCM_RATIO_RST);
    // Halving may rise only while the ratio is zero; clearing always allowed
    wire next_halve = merged[PCM_HALVE_BIT] & (ratio_zero | input_halving_select);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_src <= PCM_SRC_RST;
            pll_ratio_reg <= PCM_RATIO_RST;
            input_halving_select <= 1'b0;
            pll_power_off_bit <= 1'b0;
            lpm_sel <= PCM_LPM_RST;
        end else if (clk_en) begin
            if (wr_fire && hit_clock_out_pin_control) begin
                clk_src <= merged[PCM_SRC_LSB +: 2];
            end
            if (wr_ratio) begin
                pll_ratio_reg <= new_ratio;
            end
            if (wr_sts) begin
                input_halving_select <= next_halve;
                pll_power_off_bit <= merged[PCM_PLL_OFF_BIT];
            end
            if (wr_fire && hit_lpm) begin
                lpm_sel <= merged[1:0];
            end
        end
    end

    // ==========================================================
    // Lock sequence
    wire [PCM_LOCK_W-1:0] lock_load = PCM_LOCK_W'(LOCK_OSC_CYCLES - 1);
    pcm_mode_t next_mode;
    logic [PCM_LOCK_W-1:0] next_lock_cnt;

    always_comb begin
        next_mode = mode;
        next_lock_cnt = lock_cnt;
        if (wr_ratio) begin
            // Every accepted ratio write reloads the count; nonzero ones restart the lock wait
            next_mode = (new_ratio == PCM_RATIO_RST) ? PCM_BYPASS : PCM_LOCKING;
            next_lock_cnt = lock_load;
        end else begin
            case (mode)
                PCM_BYPASS: begin
                    next_mode = PCM_BYPASS;
                end
                PCM_LOCKING: begin
                    if (osc_rise) begin
                        if (lock_cnt == '0) begin
                            next_mode = PCM_PLL;
                        end else begin
                            next_lock_cnt = lock_cnt - PCM_LOCK_W'(1);
                        end
                    end
                end
                PCM_PLL: begin
                    next_mode = PCM_PLL;
                end
                default: begin
                    next_mode = PCM_BYPASS;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= PCM_BYPASS;
            lock_cnt <= '0;
        end else if (clk_en) begin
            mode <= next_mode;
            lock_cnt <= next_lock_cnt;
        end
    end

    // ==========================================================
    // Low-power entry: idle request stops clocks in standby or halt
    wire wake = ~sync_b[2];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lpm_stop <= 1'b0;
        end else if (clk_en) begin
            if (idle_req && lpm_sel != PCM_LPM_IDLE) begin
                lpm_stop <= 1'b1;
            end else if (wake) begin
                lpm_stop <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Clock synthesis
    // Power-off or bypass both take the oscillator path
    wire use_mult = pll_locked & ~pll_power_off_bit;
    logic [PCM_PERIOD_W-1:0] acc;
    wire [PCM_PERIOD_W:0] acc_sum = {1'b0, acc} + (PCM_PERIOD_W + 1)'(pll_ratio_reg);
    wire acc_wrap = (acc_sum >= {1'b0, osc_period});
    wire [PCM_PERIOD_W-1:0] next_acc =
        acc_wrap ? PCM_PERIOD_W'(acc_sum - {1'b0, osc_period}) : acc_sum[PCM_PERIOD_W-1:0];
    logic clk_q;
    logic next_clk;

    always_comb begin
        if (lpm_stop) begin
            next_clk = 1'b0;
        end else if (use_mult) begin
            next_clk = clk_q ^ acc_wrap;
        end else if (input_halving_select) begin
            next_clk = osc_level;
        end else begin
            next_clk = clk_q ^ osc_rise;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc <= '0;
            clk_q <= 1'b0;
        end else if (clk_en) begin
            acc <= use_mult ? next_acc : '0;
            clk_q <= next_clk;
        end
    end

    // Same flop feeds both so the rates cannot differ
    assign cpu_clock_in = clk_q;
    assign system_clock_out = clk_q;

    assign clk_status.bypass = ~use_mult;
    assign clk_status.pll_locked = pll_locked;
    assign clk_status.lpm_stopped = lpm_stop;
    assign clk_status.halted = halted;

endmodule : pcm_clock_module

// ==== pcm_clock_module_properties.sv ====
// Purpose: Port-level properties of the PLL clock module
// Assumes: clk_en held high by the bench
// Notes: Bound to the top module from tb
`timescale 1ns/1ps
module pcm_clock_module_properties #(
    parameter int LOCK_OSC_CYCLES = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic [pcm_pkg::PCM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic protected_write_enable,
    // Clocks and status
    input wire logic cpu_clock_in,
    input wire logic system_clock_out,
    input wire pcm_pkg::pcm_clk_status_t clk_status
);
    import pcm_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Helpers
    logic ratio_hit;
    logic ratio_nz;
    logic [19:0] since;
    assign ratio_hit = avs_write && !avs_waitrequest && avs_address[16:2] == PCM_IDX_PLL_RATIO;
    assign ratio_nz = ratio_hit && protected_write_enable && avs_writedata[3:0] != 4'h0
        && avs_writedata[3:0] <= PCM_RATIO_MAX;
    // Cycles since the last accepted nonzero ratio write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since <= 20'h00000;
        end else if (ratio_nz) begin
            since <= 20'h00000;
        end else if (since != 20'hFFFFF) begin
            since <= since + 20'h00001;
        end
    end
    // ==========================================================
    // Assertions
    a_clocks_same: assert property (cpu_clock_in == system_clock_out)
        else $error("cpu clock and system clock differ");
    a_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 avs_waitrequest
        ##1 !avs_waitrequest) else $error("write answer not at third edge");
    a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
        else $error("read answer not at third edge");
    a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_reset_bypass: assert property ($fell(rst)
        |-> clk_status.bypass && !clk_status.pll_locked)
        else $error("not in bypass after reset");
    a_ratio_bypass: assert property (ratio_nz
        |=> (clk_status.bypass && !clk_status.pll_locked) [*8])
        else $error("multiplied clock before lock");
    a_lock_time: assert property ($rose(clk_status.pll_locked)
        |-> since >= 20'((LOCK_OSC_CYCLES - 1) * 4))
        else $error("lock came too early");
    a_protect_hold: assert property (ratio_hit && !protected_write_enable
        && clk_status.pll_locked |=> clk_status.pll_locked)
        else $error("unprotected ratio write took effect");
    a_reserved_hold: assert property (ratio_hit && avs_writedata[3:0] > PCM_RATIO_MAX
        && clk_status.pll_locked |=> clk_status.pll_locked) else $error("reserved ratio taken");
    a_stop_clocks: assert property (clk_status.lpm_stopped
        && $past(clk_status.lpm_stopped) |-> !cpu_clock_in)
        else $error("clock runs while stopped");
    c_locked: cover property ($rose(clk_status.pll_locked));
    c_stopped: cover property ($rose(clk_status.lpm_stopped));
    c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule : pcm_clock_module_properties

// ==== pcm_osc_model.sv ====
// Purpose: Oscillator source feeding the clock pins
// Assumes: Half period far above four sys_clk periods
// Notes: The pin not in use is held low
`timescale 1ns/1ps
module pcm_osc_model #(
    parameter real HALF_NS = 40.0
) (
    // Source select
    input wire logic sel_ext,
    // Pins
    output logic low_voltage_clock_pin,
    output logic ext_clock_pin
);
    logic osc = 1'b0;
    initial begin
        #1.3;
        forever #(HALF_NS) osc = ~osc;
    end
    assign low_voltage_clock_pin = sel_ext ? 1'b0 : osc;
    assign ext_clock_pin = sel_ext ? osc : 1'b0;
endmodule : pcm_osc_model

// ==== tb.sv ====
// Purpose: Self-checking bench of the PLL clock module
// Assumes: Oscillator period 16 sys_clk cycles, lock count 8
// Notes: Periods measured over four cycles of cpu_clock_in
`timescale 1ns/1ps
module tb;
    import pcm_pkg::*;
    localparam int LOCK = 8;
    localparam int OSC = 16;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [16:0] avs_address = 17'h00000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic protected_write_enable = 1'b1;
    logic idle_req = 1'b0;
    logic wake_n = 1'b1;
    logic osc_sel = 1'b0;
    logic lv_pin, ext_pin, xdrive, xdrive_oe, cpu_clk, sys_out;
    pcm_clk_status_t clk_status;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic [31:0] rd;
    always #2.5 sys_clk = ~sys_clk;
    pcm_osc_model osc_m (
        .sel_ext(osc_sel), .low_voltage_clock_pin(lv_pin), .ext_clock_pin(ext_pin)
    );
    pcm_clock_module #(.LOCK_OSC_CYCLES(LOCK)) uut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .protected_write_enable(protected_write_enable),
        .idle_req(idle_req), .low_voltage_clock_pin(lv_pin), .ext_clock_pin(ext_pin),
        .crystal_drive_pin(xdrive), .crystal_drive_oe(xdrive_oe), .wake_n(wake_n),
        .cpu_clock_in(cpu_clk), .system_clock_out(sys_out), .clk_status(clk_status)
    );
    // ==========================================================
    // Tasks
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_ack();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) check("bus answer", 32'h1, 32'h0);
    endtask : wait_ack
    task automatic bus_write(input logic [14:0] idx, input logic [15:0] d);
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, d};
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask : bus_write
    task automatic read_check(input string what, input logic [14:0] idx, input logic [15:0] exp);
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        wait_ack();
        rd = avs_readdata;
        avs_read <= 1'b0;
        check(what, {16'h0000, exp}, rd);
    endtask : read_check
    task automatic measure(input string what, input int exp);
        logic prev;
        int c;
        int g;
        prev = cpu_clk;
        n = 0;
        c = -1;
        g = 0;
        while (n < 5 && g < 3000) begin
            @(posedge sys_clk);
            g++;
            if (c >= 0) c++;
            if (cpu_clk === 1'b1 && prev === 1'b0) begin
                n++;
                if (c < 0) c = 0;
            end
            prev = cpu_clk;
        end
        check(what, 32'(exp), 32'(c));
    endtask : measure
    task automatic wait_lock();
        int c;
        c = 0;
        while (clk_status.pll_locked !== 1'b1 && c < 2000) begin
            @(posedge sys_clk);
            c++;
        end
        check("lock wait in range", 32'h1,
            {31'h0, c >= (LOCK - 1) * OSC && c <= (LOCK + 3) * OSC});
    endtask : wait_lock
    // ==========================================================
    // Timeout and sequence
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("status after reset", 32'h8, {28'h0, clk_status});
        check("amplifier on", 32'h1, {31'h0, xdrive_oe});
        wait (lv_pin === 1'b0);
        wait (lv_pin === 1'b1);
        repeat (4) @(posedge sys_clk);
        check("crystal drive", 32'h0, {31'h0, xdrive});
        read_check("ratio after reset", PCM_IDX_PLL_RATIO, 16'h0000);
        measure("bypass period", 8 * OSC);
        bus_write(15'h7012, 16'h1234);
        read_check("unmapped read", 15'h7012, 16'h0000);
        protected_write_enable <= 1'b0;
        bus_write(PCM_IDX_PLL_RATIO, 16'h0005);
        bus_write(PCM_IDX_PCLK_GATE2, 16'hA5C3);
        read_check("ratio unprotected", PCM_IDX_PLL_RATIO, 16'h0000);
        read_check("gate unprotected", PCM_IDX_PCLK_GATE2, 16'h0000);
        protected_write_enable <= 1'b1;
        bus_write(PCM_IDX_PCLK_GATE2, 16'hA5C3);
        read_check("gate protected", PCM_IDX_PCLK_GATE2, 16'hA5C3);
        bus_write(PCM_IDX_PLL_STATUS, 16'h0002);
        read_check("halving set", PCM_IDX_PLL_STATUS, 16'h0002);
        measure("halved period", 4 * OSC);
        bus_write(PCM_IDX_PLL_STATUS, 16'h0000);
        bus_write(PCM_IDX_WD_CTRL, 16'h0068);
        bus_write(PCM_IDX_PLL_RATIO, 16'h0004);
        @(posedge sys_clk);
        check("bypass while locking", 32'h8, {28'h0, clk_status});
        wait_lock();
        read_check("locked flag", PCM_IDX_PLL_STATUS, 16'h0001);
        protected_write_enable <= 1'b0;
        bus_write(PCM_IDX_PLL_RATIO, 16'h0000);
        protected_write_enable <= 1'b1;
        read_check("lock kept unprotected", PCM_IDX_PLL_STATUS, 16'h0001);
        measure("ratio four period", 2 * OSC);
        bus_write(PCM_IDX_PLL_STATUS, 16'h0002);
        read_check("halving refused", PCM_IDX_PLL_STATUS, 16'h0001);
        for (int v = 11; v < 16; v++) begin
            bus_write(PCM_IDX_PLL_RATIO, 16'(v));
            read_check("ratio after reserved", PCM_IDX_PLL_RATIO, 16'h0004);
        end
        for (int v = 1; v <= 10; v++) begin
            bus_write(PCM_IDX_PLL_RATIO, 16'(v));
            read_check("ratio readback", PCM_IDX_PLL_RATIO, 16'(v));
        end
        bus_write(PCM_IDX_PLL_RATIO, 16'h0008);
        wait_lock();
        measure("ratio eight period", OSC);
        bus_write(PCM_IDX_PLL_RATIO, 16'h0008);
        @(posedge sys_clk);
        check("same value relocks", 32'h8, {28'h0, clk_status});
        wait_lock();
        bus_write(PCM_IDX_PLL_RATIO, 16'h0000);
        bus_write(PCM_IDX_PLL_STATUS, 16'h0008);
        measure("power off period", 8 * OSC);
        bus_write(PCM_IDX_PLL_STATUS, 16'h0000);
        osc_sel <= 1'b1;
        bus_write(PCM_IDX_CLK_OUT_PIN, 16'h0008);
        repeat (100) @(posedge sys_clk);
        check("amplifier off", 32'h0, {31'h0, xdrive_oe});
        measure("external pin period", 8 * OSC);
        bus_write(PCM_IDX_LOW_POWER, 16'h0001);
        @(posedge sys_clk);
        idle_req <= 1'b1;
        @(posedge sys_clk);
        idle_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("stopped flag", 32'h1, {31'h0, clk_status.lpm_stopped});
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (cpu_clk !== 1'b0) n++;
        end
        check("clock while stopped", 32'h0, 32'(n));
        wake_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wake_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("stop cleared", 32'h0, {31'h0, clk_status.lpm_stopped});
        bus_write(PCM_IDX_LOW_POWER, 16'h0002);
        idle_req <= 1'b1;
        @(posedge sys_clk);
        idle_req <= 1'b0;
        @(posedge sys_clk);
        check("halt status", 32'hB, {28'h0, clk_status});
        close_out();
    end
endmodule : tb
bind pcm_clock_module pcm_clock_module_properties #(.LOCK_OSC_CYCLES(LOCK_OSC_CYCLES)) u_props (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .protected_write_enable(protected_write_enable), .cpu_clock_in(cpu_clock_in),
    .system_clock_out(system_clock_out), .clk_status(clk_status)
);
